// *** hdl/ctmr_top.sv ***
// Top of the counter/timer block: processor bus decode, channel select,
// vector supply, daisy chain and return-opcode watch.
// Assumes processor strobes are synchronous to clk and one bus cycle spans
// at least two clocks; the wire level of irq_n comes from out/oe outside.
`timescale 1ns/100ps
`include "ctmr_consts.svh"
module ctmr_top
   import ctmr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic chan_sel_0,
   input wire logic chan_sel_1,
   input wire logic io_request_n,
   input wire logic read_strobe_n,
   input wire logic opcode_fetch_cycle_n,
   input wire logic priority_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [3:0] ext_edge_input,
   output logic [2:0] terminal_pulse,
   output logic irq_n_out,
   output logic irq_n_oe,
   output logic priority_out
);

   // ------------------------------------------------------------
   // Bus cycle decode
   // ------------------------------------------------------------
   ctmr_chan_t sel;
   logic io_wr_cond, io_rd_cond, ack_cond, fetch_cond;
   logic wr_prev_q, ack_prev_q, fetch_prev_q;
   logic wr_go, ack_go, fetch_end;

   always_comb
   begin
      sel = {chan_sel_1, chan_sel_0};
      // No write pin: a write is an I/O cycle with the read strobe high
      io_wr_cond = !io_request_n && !chip_select_n && read_strobe_n &&
         opcode_fetch_cycle_n;
      io_rd_cond = !io_request_n && !chip_select_n && !read_strobe_n &&
         opcode_fetch_cycle_n;
      ack_cond = !io_request_n && !opcode_fetch_cycle_n;
      fetch_cond = !opcode_fetch_cycle_n && !read_strobe_n &&
         io_request_n;
      wr_go = io_wr_cond && !wr_prev_q;
      fetch_end = fetch_prev_q && !fetch_cond;
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   ctmr_chan_if chif[`CTMR_NCH] ();
   ctmr_byte_t cnt [`CTMR_NCH];
   logic [3:0] zero, ie, tcp, req_drop;
   logic wr_tc_sel, wr_ctl_sel, wr_vec;

   always_comb
   begin
      // A channel expecting a time constant takes the next byte as such
      wr_tc_sel = wr_go && tcp[sel];
      wr_ctl_sel = wr_go && !tcp[sel] && data_in[`CTMR_CW_CTL];
      wr_vec = wr_go && !tcp[sel] && !data_in[`CTMR_CW_CTL];
   end

   genvar g;
   generate
      for (g = 0; g < `CTMR_NCH; g++)
      begin : g_ch
         assign chif[g].wr_ctl = wr_ctl_sel && (sel == g);
         assign chif[g].wr_tc = wr_tc_sel && (sel == g);
         assign chif[g].wdata = data_in;
         assign cnt[g] = chif[g].count;
         assign zero[g] = chif[g].zero;
         assign ie[g] = chif[g].int_en;
         assign tcp[g] = chif[g].tc_pend;
         assign req_drop[g] = !chif[g].int_en;

         ctmr_channel u_chan
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .ext_edge_input(ext_edge_input[g]),
            .bus(chif[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Interrupt priority
   // ------------------------------------------------------------
   logic [3:0] in_svc;
   ctmr_chan_t ack_chan;
   logic req_any, return_from_irq_opcode_pulse;

   always_comb
   begin
      // Acknowledge is taken once, only with chain priority and a request
      ack_go = ack_cond && !ack_prev_q && priority_in && req_any;
   end

   ctmr_irq_ctrl u_irq
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .req_set(zero & ie),
      .req_drop(req_drop),
      .ack_take(ack_go),
      .return_from_irq_opcode_seen(return_from_irq_opcode_pulse),
      .in_svc(in_svc),
      .ack_chan(ack_chan),
      .req_any(req_any)
   );

   // ------------------------------------------------------------
   // Vector base register
   // ------------------------------------------------------------
   ctmr_byte_t vec_q, vec_d;

   always_comb
   begin
      vec_d = vec_q;
      if (wr_vec)
         vec_d = data_in;
   end

   // ------------------------------------------------------------
   // Return-from-interrupt watch
   // ------------------------------------------------------------
   // The opcode is sampled each fetch clock and judged when the fetch
   // ends, so late-settling bus data is what counts.
   ctmr_opst_t op_st_q, op_st_d;
   ctmr_byte_t op_q;
   logic return_from_irq_opcode_d, return_from_irq_opcode_q;

   always_comb
   begin
      op_st_d = op_st_q;
      return_from_irq_opcode_d = 1'b0;
      if (fetch_end)
      begin
         unique case (op_st_q)
            CTMR_OP_IDLE:
               if (op_q == `CTMR_RETURN_FROM_IRQ_OPCODE_B0)
                  op_st_d = CTMR_OP_PREFIX;
            CTMR_OP_PREFIX:
            begin
               if (op_q == `CTMR_RETURN_FROM_IRQ_OPCODE_B1)
               begin
                  return_from_irq_opcode_d = 1'b1;
                  op_st_d = CTMR_OP_IDLE;
               end
               else if (op_q != `CTMR_RETURN_FROM_IRQ_OPCODE_B0)
                  op_st_d = CTMR_OP_IDLE;
            end
         endcase
      end
   end

   assign return_from_irq_opcode_pulse = return_from_irq_opcode_q;

   // ------------------------------------------------------------
   // Data bus and pin outputs
   // ------------------------------------------------------------
   ctmr_byte_t dout_q, dout_d;
   logic doe_q, doe_d, vec_hold_q, vec_hold_d;
   logic irq_oe_q, irq_oe_d, prio_q, prio_d;
   logic [2:0] tp_q, tp_d;

   always_comb
   begin
      dout_d = dout_q;
      doe_d = 1'b0;
      vec_hold_d = vec_hold_q && ack_cond;
      if (ack_go)
      begin
         dout_d = {vec_q[`CTMR_VEC_HI:`CTMR_VEC_LO], ack_chan,
            1'b0};
         doe_d = 1'b1;
         vec_hold_d = 1'b1;
      end
      else if (vec_hold_q && ack_cond)
         doe_d = 1'b1;
      else if (io_rd_cond)
      begin
         dout_d = cnt[sel];
         doe_d = 1'b1;
      end
      // During reset the chain passes straight through
      prio_d = priority_in && (sys_rst || !(|in_svc));
      irq_oe_d = req_any;
      tp_d = zero[`CTMR_NZC-1:0];
   end

   always_ff @(posedge clk)
   begin
      prio_q <= prio_d;
      if (sys_rst)
      begin
         wr_prev_q <= 1'b0;
         ack_prev_q <= 1'b0;
         fetch_prev_q <= 1'b0;
         vec_q <= `CTMR_VEC_RST;
         op_st_q <= CTMR_OP_IDLE;
         op_q <= `CTMR_BYTE_ZERO;
         return_from_irq_opcode_q <= 1'b0;
         dout_q <= `CTMR_BYTE_ZERO;
         doe_q <= 1'b0;
         vec_hold_q <= 1'b0;
         irq_oe_q <= 1'b0;
         tp_q <= 3'h0;
      end
      else
      begin
         wr_prev_q <= io_wr_cond;
         ack_prev_q <= ack_cond;
         fetch_prev_q <= fetch_cond;
         vec_q <= vec_d;
         op_st_q <= op_st_d;
         if (fetch_cond)
            op_q <= data_in;
         return_from_irq_opcode_q <= return_from_irq_opcode_d;
         dout_q <= dout_d;
         doe_q <= doe_d;
         vec_hold_q <= vec_hold_d;
         irq_oe_q <= irq_oe_d;
         tp_q <= tp_d;
      end
   end

   assign data_out = dout_q;
   assign data_oe = doe_q;
   assign irq_n_oe = irq_oe_q;
   // Open drain: only ever pulls low, the enable does the signalling
   assign irq_n_out = 1'b0;
   assign priority_out = prio_q;
   assign terminal_pulse = tp_q;
endmodule

// *** pkg/ctmr_consts.svh ***
// Constants of the four-channel counter/timer bus and interrupt block.
// Assumes inclusion by bare name from packages and modules that need it.
//
// Behaviour
// - Channel 0 has highest interrupt priority, channel 3 the lowest.
// - Lower channels wait while higher ones are in service; higher may nest.
// - Zero count on an interrupt-enabled channel asserts open-drain irq_n.
// - Acknowledge with priority_in high drives the winning channel's vector.
// - Vector bits 7..3 come from software, bits 2..1 are the channel code.
// - Vector bit 0 is zero; written byte bit 0 picks vector or control.
// - Return-from-interrupt opcode on fetches ends the in-service state.
// - priority_out high only with priority_in high and nothing in service.
// - chan_sel_1 and chan_sel_0 form the 2-bit channel number.
// - Register access only while chip_select_n is low in an I/O cycle.
// - Write is I/O request with read strobe high; no write pin exists.
// - I/O read drives the selected channel's down-counter on the bus.
// - Opcode fetch with read strobe is never answered as an I/O read.
// - Reset stops channels, clears enables, idles outputs, frees the bus.
// - Edge polarity selectable; counts in counter mode, starts the timer.
// - Zero count pulses terminal_pulse on channels 0 to 2 only.
// - Control word bits 7..1 select enable, mode, prescale, edge, etc.
// - Time constant 1..256 loads counter; new value waits for zero.
// - Timer mode prescaler divides the system clock by 16 or 256.
`ifndef CTMR_CONSTS_SVH
`define CTMR_CONSTS_SVH
`define CTMR_NCH 4
`define CTMR_NZC 3
`define CTMR_CW_IE 7
`define CTMR_CW_CNT 6
`define CTMR_CW_P256 5
`define CTMR_CW_RISE 4
`define CTMR_CW_TRIG 3
`define CTMR_CW_TCF 2
`define CTMR_CW_SRST 1
`define CTMR_CW_CTL 0
`define CTMR_VEC_HI 7
`define CTMR_VEC_LO 3
`define CTMR_PRE16_MAX 8'h0f
`define CTMR_PRE256_MAX 8'hff
`define CTMR_CNT_LAST 8'h01
`define CTMR_RETURN_FROM_IRQ_OPCODE_B0 8'hed
`define CTMR_RETURN_FROM_IRQ_OPCODE_B1 8'h4d
`define CTMR_CW_RST 8'h00
`define CTMR_TC_RST 8'h00
`define CTMR_VEC_RST 8'h00
`define CTMR_BYTE_ZERO 8'h00
`endif

// *** pkg/ctmr_pkg.sv ***
// Types and shared decode functions of the counter/timer block.
// Assumes the constants header sits beside it.
`include "ctmr_consts.svh"
package ctmr_pkg;
   typedef logic [7:0] ctmr_byte_t;
   typedef logic [1:0] ctmr_chan_t;
   typedef enum logic [1:0] {CTMR_STOP = 2'b00, CTMR_ARMED = 2'b01,
      CTMR_RUN = 2'b10} ctmr_chst_t;
   typedef enum logic {CTMR_OP_IDLE = 1'b0, CTMR_OP_PREFIX = 1'b1}
      ctmr_opst_t;

   // Timer with trigger bit waits for an edge; all else runs at once
   function automatic ctmr_chst_t ctmr_start_st(input ctmr_byte_t cw);
      ctmr_start_st = (!cw[`CTMR_CW_CNT] && cw[`CTMR_CW_TRIG]) ?
         CTMR_ARMED : CTMR_RUN;
   endfunction

   // Lowest set bit wins: channel 0 is the highest priority
   function automatic ctmr_chan_t ctmr_first(input logic [3:0] v);
      ctmr_first = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction
endpackage

// *** pkg/ctmr_chan_if.sv ***
// Link between the bus front end and one counter/timer channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface ctmr_chan_if;
   import ctmr_pkg::*;
   logic wr_ctl;
   logic wr_tc;
   ctmr_byte_t wdata;
   ctmr_byte_t count;
   logic zero;
   logic int_en;
   logic tc_pend;
   modport host (output wr_ctl, output wr_tc, output wdata,
      input count, input zero, input int_en, input tc_pend);
   modport chan (input wr_ctl, input wr_tc, input wdata,
      output count, output zero, output int_en, output tc_pend);
endinterface

// *** hdl/ctmr_channel.sv ***
// One counter/timer channel: control, time constant, down-counter, prescaler.
// Assumes write strobes are single-cycle pulses and ext input is synchronous.
`timescale 1ns/100ps
`include "ctmr_consts.svh"
module ctmr_channel
   import ctmr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ext_edge_input,
   ctmr_chan_if.chan bus
);
   ctmr_byte_t ctl_q, ctl_d, tc_q, tc_d, cnt_q, cnt_d, pre_q, pre_d;
   ctmr_chst_t st_q, st_d;
   logic ext_q, tcp_q, tcp_d, tcok_q, tcok_d, zero_q, zero_d;
   logic edge_hit, tick;
   ctmr_byte_t pre_max;

   always_comb
   begin
      edge_hit = ctl_q[`CTMR_CW_RISE] ? (ext_edge_input & ~ext_q) :
         (~ext_edge_input & ext_q);
      pre_max = ctl_q[`CTMR_CW_P256] ? `CTMR_PRE256_MAX :
         `CTMR_PRE16_MAX;
      tick = (st_q == CTMR_RUN) &&
         (ctl_q[`CTMR_CW_CNT] ? edge_hit : (pre_q == pre_max));
      ctl_d = ctl_q;
      tc_d = tc_q;
      cnt_d = cnt_q;
      pre_d = pre_q;
      st_d = st_q;
      tcp_d = tcp_q;
      tcok_d = tcok_q;
      zero_d = 1'b0;
      unique case (st_q)
         CTMR_STOP:
         begin
         end
         CTMR_ARMED:
            if (edge_hit)
            begin
               st_d = CTMR_RUN;
               pre_d = `CTMR_BYTE_ZERO;
            end
         CTMR_RUN:
         begin
            pre_d = (pre_q == pre_max) ? `CTMR_BYTE_ZERO : pre_q + 8'h01;
            if (tick)
            begin
               // Count of 0 stands for 256: 1 is the last step before zero
               if (cnt_q == `CTMR_CNT_LAST)
               begin
                  cnt_d = tc_q;
                  zero_d = 1'b1;
               end
               else
                  cnt_d = cnt_q - 8'h01;
            end
         end
         default: st_d = CTMR_STOP;
      endcase
      if (bus.wr_tc)
      begin
         tc_d = bus.wdata;
         tcp_d = 1'b0;
         tcok_d = 1'b1;
         // A running channel finishes its count before the new value
         if (st_q != CTMR_RUN)
         begin
            cnt_d = bus.wdata;
            pre_d = `CTMR_BYTE_ZERO;
            st_d = ctmr_start_st(ctl_q);
         end
      end
      if (bus.wr_ctl)
      begin
         ctl_d = bus.wdata;
         tcp_d = bus.wdata[`CTMR_CW_TCF];
         if (bus.wdata[`CTMR_CW_SRST])
            st_d = CTMR_STOP;
         else if (!bus.wdata[`CTMR_CW_TCF] && tcok_q && st_q == CTMR_STOP)
         begin
            cnt_d = tc_q;
            pre_d = `CTMR_BYTE_ZERO;
            st_d = ctmr_start_st(bus.wdata);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ctl_q <= `CTMR_CW_RST;
         tc_q <= `CTMR_TC_RST;
         cnt_q <= `CTMR_TC_RST;
         pre_q <= `CTMR_BYTE_ZERO;
         st_q <= CTMR_STOP;
         tcp_q <= 1'b0;
         tcok_q <= 1'b0;
         zero_q <= 1'b0;
         ext_q <= 1'b0;
      end
      else
      begin
         ctl_q <= ctl_d;
         tc_q <= tc_d;
         cnt_q <= cnt_d;
         pre_q <= pre_d;
         st_q <= st_d;
         tcp_q <= tcp_d;
         tcok_q <= tcok_d;
         zero_q <= zero_d;
         ext_q <= ext_edge_input;
      end
   end

   assign bus.count = cnt_q;
   assign bus.zero = zero_q;
   assign bus.int_en = ctl_q[`CTMR_CW_IE];
   assign bus.tc_pend = tcp_q;
endmodule

// *** hdl/ctmr_irq_ctrl.sv ***
// Pending and in-service bookkeeping with fixed channel priority.
// Assumes ack and return pulses last one cycle each.
`timescale 1ns/100ps
`include "ctmr_consts.svh"
module ctmr_irq_ctrl
   import ctmr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] req_set,
   input wire logic [3:0] req_drop,
   input wire logic ack_take,
   input wire logic return_from_irq_opcode_seen,
   output logic [3:0] in_svc,
   output ctmr_chan_t ack_chan,
   output logic req_any
);
   logic [3:0] pend_q, pend_d, svc_q, svc_d, blocked, elig;

   genvar g;
   generate
      for (g = 0; g < `CTMR_NCH; g++)
      begin : g_blk
         // A channel is blocked by itself or any higher one in service
         assign blocked[g] = |svc_q[g:0];
      end
   endgenerate

   always_comb
   begin
      elig = pend_q & ~blocked;
      pend_d = pend_q & ~req_drop;
      svc_d = svc_q;
      if (ack_take)
      begin
         pend_d[ctmr_first(elig)] = 1'b0;
         svc_d[ctmr_first(elig)] = 1'b1;
      end
      if (return_from_irq_opcode_seen && |svc_q)
         svc_d[ctmr_first(svc_q)] = 1'b0;
      // A new zero count wins over a clear in the same cycle
      pend_d = pend_d | req_set;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pend_q <= 4'h0;
         svc_q <= 4'h0;
      end
      else
      begin
         pend_q <= pend_d;
         svc_q <= svc_d;
      end
   end

   assign in_svc = svc_q;
   assign ack_chan = ctmr_first(elig);
   assign req_any = |elig;
endmodule

// *** verif/ctmr_top_assertions.sv ***
// Port-level checks of the counter/timer bus and interrupt top.
// Assumes binding to ctmr_top; everything runs on clk.
`timescale 1ns/100ps
module ctmr_top_assertions
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic chip_select_n,
   input wire logic io_request_n,
   input wire logic read_strobe_n,
   input wire logic opcode_fetch_cycle_n,
   input wire logic priority_in,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [2:0] terminal_pulse,
   input wire logic irq_n_out,
   input wire logic irq_n_oe,
   input wire logic priority_out
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_reset_idle: assert property (
      $fell(sys_rst) |-> !data_oe && !irq_n_oe && terminal_pulse == 3'h0)
      else $error("outputs not idle after reset");
   a_chain_follow: assert property (
      priority_out |-> $past(priority_in))
      else $error("chain out high without chain in");
   a_ack_blocks: assert property (
      data_oe && $past(!opcode_fetch_cycle_n) |=> !priority_out)
      else $error("chain out high while in service");
   a_fetch_silent: assert property (
      $past(!opcode_fetch_cycle_n && io_request_n) |-> !data_oe)
      else $error("bus driven during opcode fetch");
   a_read_drives: assert property (
      $past(!io_request_n && !chip_select_n && !read_strobe_n &&
      opcode_fetch_cycle_n) |-> data_oe)
      else $error("read not answered");
   a_drive_cause: assert property (
      data_oe |-> $past(!io_request_n))
      else $error("bus driven outside an I/O cycle");
   a_read_needs_cs: assert property (
      data_oe && $past(opcode_fetch_cycle_n) |->
      $past(!chip_select_n && !read_strobe_n))
      else $error("bus driven without select and read");
   a_vec_shape: assert property (
      data_oe && $past(!opcode_fetch_cycle_n) |->
      !data_out[0] && $past(priority_in))
      else $error("bad vector or chain not granted");
   a_pulse_single: assert property (
      |terminal_pulse |=> (terminal_pulse & $past(terminal_pulse)) == 3'h0)
      else $error("terminal pulse longer than a cycle");
   a_irq_pull_low: assert property (
      irq_n_oe |-> irq_n_out == 1'b0)
      else $error("request not pulled low");
endmodule

// *** verif/ctmr_cpu_model.sv ***
// Processor bus model: I/O, acknowledge and opcode fetch cycles.
// Assumes one caller at a time; strobes move only after falling edges.
`timescale 1ns/100ps
module ctmr_cpu_model
(
   input wire logic clk,
   output logic chip_select_n,
   output logic chan_sel_0,
   output logic chan_sel_1,
   output logic io_request_n,
   output logic read_strobe_n,
   output logic opcode_fetch_cycle_n,
   output logic [7:0] bus_d
);
   initial
   begin
      {chip_select_n, io_request_n, read_strobe_n} = 3'h7;
      opcode_fetch_cycle_n = 1'b1;
      {chan_sel_1, chan_sel_0} = 2'h0;
      bus_d = 8'h00;
   end

   // ----------------------------------------
   // Bus cycle
   // ----------------------------------------
   // Released data shows the inverse of the last byte so it never matches
   task cyc(input logic [1:0] ch, input logic cs_n, input logic io_request_n_n,
      input logic rd_n, input logic m1_n, input logic [7:0] d, input int n);
      @(negedge clk);
      {chan_sel_1, chan_sel_0} = ch;
      chip_select_n = cs_n;
      io_request_n = io_request_n_n;
      read_strobe_n = rd_n;
      opcode_fetch_cycle_n = m1_n;
      bus_d = d;
      repeat (n) @(negedge clk);
      {chip_select_n, io_request_n, read_strobe_n} = 3'h7;
      opcode_fetch_cycle_n = 1'b1;
      bus_d = ~d;
   endtask
endmodule

// *** verif/ctmr_top_tb.sv ***
// Self-checking bench of the counter/timer bus and interrupt block.
// Assumes the processor model owns the bus strobes; this drives the rest.
`timescale 1ns/100ps
module ctmr_top_tb;
   import ctmr_pkg::*;
   logic clk = 1'b0;
   logic sys_rst, priority_in, data_oe, irq_n_out, irq_n_oe, priority_out;
   logic chip_select_n, chan_sel_0, chan_sel_1, io_request_n, irq_n;
   logic read_strobe_n, opcode_fetch_cycle_n, oe_q;
   logic [7:0] data_in, data_out, bus_d;
   logic [3:0] ext_edge_input;
   logic [2:0] terminal_pulse;
   logic [2:0] tp_seen = 3'h0;
   logic [7:0] q[$];
   ctmr_byte_t base, tc;
   logic [31:0] rnd;
   int miscompares = 0;
   int check_count = 0;
   int cyc_n = 0;
   int tp_last = 0;
   int tp_gap = 0;

   assign irq_n = irq_n_oe ? irq_n_out : 1'b1;
   assign data_in = data_oe ? data_out : bus_d;

   ctmr_cpu_model cpu_u (.clk(clk), .chip_select_n(chip_select_n),
      .chan_sel_0(chan_sel_0), .chan_sel_1(chan_sel_1),
      .io_request_n(io_request_n), .read_strobe_n(read_strobe_n),
      .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .bus_d(bus_d));

   ctmr_top dut_u (.clk(clk), .sys_rst(sys_rst),
      .chip_select_n(chip_select_n), .chan_sel_0(chan_sel_0),
      .chan_sel_1(chan_sel_1), .io_request_n(io_request_n),
      .read_strobe_n(read_strobe_n),
      .opcode_fetch_cycle_n(opcode_fetch_cycle_n),
      .priority_in(priority_in), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .ext_edge_input(ext_edge_input),
      .terminal_pulse(terminal_pulse), .irq_n_out(irq_n_out),
      .irq_n_oe(irq_n_oe), .priority_out(priority_out));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   always #10 clk = ~clk;

   always @(posedge clk)
   begin
      cyc_n++;
      if (cyc_n == 5000)
      begin
         miscompares++;
         stop_test();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic ctmr_byte_t vec(input ctmr_chan_t c);
      vec = {base[7:3], c, 1'b0};
   endfunction

   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   task wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wr(input ctmr_chan_t ch, input ctmr_byte_t d);
      cpu_u.cyc(ch, 1'b0, 1'b0, 1'b1, 1'b1, d, 2);
   endtask

   task rd(input ctmr_chan_t ch, input ctmr_byte_t e);
      q.push_back(e);
      cpu_u.cyc(ch, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 3);
   endtask

   task ack(input logic exp_on, input ctmr_byte_t e);
      if (exp_on)
         q.push_back(e);
      cpu_u.cyc(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 3);
   endtask

   task return_from_irq_opcode();
      cpu_u.cyc(2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'hed, 2);
      cpu_u.cyc(2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h4d, 2);
      wt(4);
   endtask

   task edges(input logic [3:0] m);
      repeat (2)
      begin
         ext_edge_input = m;
         wt(3);
         ext_edge_input = 4'h0;
         wt(3);
      end
   endtask

   task stop_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Each new drive cycle of the bus is one result, matched in order
   always @(negedge clk)
   begin
      if (!sys_rst && data_oe === 1'b1 && oe_q !== 1'b1)
         check(data_out, (q.size() > 0) ? q.pop_front() : 8'hxx);
      oe_q = data_oe;
      if (!sys_rst)
         tp_seen = tp_seen | terminal_pulse;
      if (terminal_pulse[2] === 1'b1)
      begin
         tp_gap = cyc_n - tp_last;
         tp_last = cyc_n;
      end
   end

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      priority_in = 1'b1;
      ext_edge_input = 4'h0;
      rnd = lfsr(32'h365a);
      base = rnd[7:0] & 8'hf8;
      rnd = lfsr(rnd);
      tc = {6'h00, rnd[1:0]} + 8'h02;
      wt(4);
      sys_rst = 1'b0;
      wt(2);
      check(8'(irq_n), 8'h01);
      check(8'(priority_out), 8'h01);
      $display("test reset done");
      wr(2'h0, base);
      cpu_u.cyc(2'h1, 1'b1, 1'b0, 1'b1, 1'b1, ~base & 8'hf8, 2);
      for (int i = 0; i < 4; i++)
      begin
         wr(2'(i), (i == 2) ? 8'hc5 : 8'hd5);
         wr(2'(i), 8'h03);
      end
      for (int i = 0; i < 4; i++)
         rd(2'(i), 8'h03);
      ext_edge_input = 4'hf;
      wt(3);
      for (int i = 0; i < 4; i++)
         rd(2'(i), (i == 2) ? 8'h03 : 8'h02);
      ext_edge_input = 4'h0;
      wt(3);
      rd(2'h2, 8'h02);
      $display("test select and count done");
      edges(4'ha);
      check(8'(tp_seen), 8'h02);
      check(8'(irq_n), 8'h00);
      priority_in = 1'b0;
      ack(1'b0, 8'h00);
      priority_in = 1'b1;
      ack(1'b1, vec(2'h1));
      wt(2);
      check(8'(priority_out), 8'h00);
      check(8'(irq_n), 8'h01);
      edges(4'h1);
      check(8'(irq_n), 8'h00);
      ack(1'b1, vec(2'h0));
      return_from_irq_opcode();
      check(8'(irq_n), 8'h01);
      return_from_irq_opcode();
      check(8'(irq_n), 8'h00);
      ack(1'b1, vec(2'h3));
      return_from_irq_opcode();
      check(8'(priority_out), 8'h01);
      check(8'(irq_n), 8'h01);
      $display("test interrupts done");
      wr(2'h2, 8'h05);
      wr(2'h2, tc);
      wt(64 * tc);
      check(8'(tp_gap), tc << 4);
      $display("test timer done");
      // Soft reset, then a triggered timer with the long prescale
      wr(2'h0, 8'h2f);
      wr(2'h0, tc);
      wt(40);
      rd(2'h0, tc);
      ext_edge_input = 4'h1;
      wt(2);
      ext_edge_input = 4'h0;
      wt(20);
      rd(2'h0, tc);
      wt(250);
      rd(2'h0, tc - 8'h01);
      $display("test trigger done");
      stop_test();
   end
endmodule

bind ctmr_top ctmr_top_assertions chk_u (.clk(clk), .sys_rst(sys_rst),
   .chip_select_n(chip_select_n), .io_request_n(io_request_n),
   .read_strobe_n(read_strobe_n),
   .opcode_fetch_cycle_n(opcode_fetch_cycle_n), .priority_in(priority_in),
   .data_out(data_out), .data_oe(data_oe), .terminal_pulse(terminal_pulse),
   .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .priority_out(priority_out));
